//--- hw/aasw_cfg_top.v
`timescale 1ns/10ps
`default_nettype none
`include "aasw_map.vh"

module aasw_cfg_top #(
  parameter ADDR_W = 4,
  parameter DATA_W = 16
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [DATA_W-1:0] reg_rdata,
  // settings presented to the access sequencer
  output wire [7:0] area_three_state,
  output wire [23:0] area_wait_count,
  // external cycle request
  input wire cyc_start,
  input wire [2:0] cyc_area,
  // settings frozen for the running cycle, and its progress
  output wire cyc_three_state,
  output wire [2:0] cyc_wait_count,
  output wire cyc_busy,
  output wire cyc_last,
  output wire [3:0] cyc_states_left
);

  // ************************************************************
  // declarations
  // ************************************************************
  localparam AREA_N = 8;

  reg [7:0] state_sel_reg;
  reg [DATA_W-1:0] rdata_reg;
  reg [DATA_W-1:0] rdata_next;
  reg cyc_three_reg;
  reg [2:0] cyc_wait_reg;
  reg [2:0] cyc_area_reg;

  wire [23:0] wait_flat;
  wire wr_state;
  wire wr_upper;
  wire wr_lower;
  wire [DATA_W-1:0] state_view;
  wire [DATA_W-1:0] upper_view;
  wire [DATA_W-1:0] lower_view;
  wire [DATA_W-1:0] status_view;
  wire [4:0] sel_base;
  wire sel_three;
  wire [2:0] sel_wait_field;
  wire [2:0] sel_wait_eff;
  wire [3:0] sel_states;
  wire take_start;
  wire timer_busy;
  wire timer_done;
  wire [3:0] timer_left;

  // ************************************************************
  // write decode
  // ************************************************************
  assign wr_state = reg_wr && (reg_addr == `AASW_OFS_ACCESS_STATE);
  assign wr_upper = reg_wr && (reg_addr == `AASW_OFS_WAIT_UPPER);
  assign wr_lower = reg_wr && (reg_addr == `AASW_OFS_WAIT_LOWER);

  // ************************************************************
  // access state selection
  // ************************************************************
  // only the upper byte is storage; the low byte does not exist
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_sel_reg <= `AASW_ACCESS_STATE_RST;
    end else if (wr_state) begin
      state_sel_reg <= reg_wdata[15:8];
    end
  end

  // ************************************************************
  // per-area wait fields
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < AREA_N; g = g + 1) begin : area_wait
      localparam integer SLOT = g % 4;
      localparam integer LSB = `AASW_WAIT_FIELD_PITCH * SLOT;
      reg [2:0] field_reg;
      wire hit;
      // areas 7..4 live in the upper register, 3..0 in the lower
      assign hit = (g >= 4) ? wr_upper : wr_lower;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          field_reg <= `AASW_WAIT_FIELD_RST;
        end else if (hit) begin
          field_reg <= reg_wdata[LSB+2:LSB];
        end
      end
      assign wait_flat[3*g+2:3*g] = field_reg;
    end
  endgenerate

  // ************************************************************
  // read views
  // ************************************************************
  assign state_view = {state_sel_reg, 8'h00};
  // gap bits are tied low, never stored
  assign upper_view = {1'b0, wait_flat[23:21], 1'b0, wait_flat[20:18],
                       1'b0, wait_flat[17:15], 1'b0, wait_flat[14:12]};
  assign lower_view = {1'b0, wait_flat[11:9], 1'b0, wait_flat[8:6],
                       1'b0, wait_flat[5:3], 1'b0, wait_flat[2:0]};
  assign status_view = {4'h0, timer_left, cyc_wait_reg, cyc_three_reg,
                        cyc_area_reg, timer_busy};

  always @* begin
    rdata_next = {DATA_W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `AASW_OFS_ACCESS_STATE: begin
          rdata_next = state_view;
        end
        `AASW_OFS_WAIT_UPPER: begin
          rdata_next = upper_view;
        end
        `AASW_OFS_WAIT_LOWER: begin
          rdata_next = lower_view;
        end
        `AASW_OFS_STATUS: begin
          rdata_next = status_view;
        end
        default: begin
          rdata_next = {DATA_W{1'b0}};
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= {DATA_W{1'b0}};
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // cycle start: pick and freeze the area's settings
  // ************************************************************
  assign sel_base = {2'b00, cyc_area} * 5'd3;
  assign sel_three = state_sel_reg[cyc_area];
  assign sel_wait_field = wait_flat[sel_base +: 3];
  // a 2-state area ignores its wait field entirely
  assign sel_wait_eff = sel_three ? sel_wait_field : 3'h0;
  assign sel_states = sel_three ?
                      (`AASW_STATES_THREE + {1'b0, sel_wait_eff}) :
                      `AASW_STATES_TWO;
  // a start during a running cycle is dropped, not queued
  assign take_start = cyc_start && !timer_busy;

  // later register writes do not disturb a cycle already running
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_three_reg <= 1'b0;
      cyc_wait_reg <= 3'h0;
      cyc_area_reg <= 3'h0;
    end else if (take_start) begin
      cyc_three_reg <= sel_three;
      cyc_wait_reg <= sel_wait_eff;
      cyc_area_reg <= cyc_area;
    end
  end

  // ************************************************************
  // cycle length timer
  // ************************************************************
  aasw_cycle_timer #(
    .CNT_W(4)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .start(take_start),
    .state_total(sel_states),
    .busy_reg(timer_busy),
    .done_reg(timer_done),
    .left_reg(timer_left)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata = rdata_reg;
  assign area_three_state = state_sel_reg;
  assign area_wait_count = wait_flat;
  assign cyc_three_state = cyc_three_reg;
  assign cyc_wait_count = cyc_wait_reg;
  assign cyc_busy = timer_busy;
  assign cyc_last = timer_done;
  assign cyc_states_left = timer_left;

endmodule

`default_nettype wire

//--- include/aasw_map.vh
`ifndef AASW_MAP_VH
`define AASW_MAP_VH
// Contract
// - state bit 0 gives 2-state cycles
// - state bit 1 gives 3-state cycles
// - state bit 0 means no waits ever
// - state bit 1 enables wait insertion too
// - state bits 15:8 areas 7..0, low zero
// - wait field counts 0 to 7 waits
// - wait count used only in 3-state
// - upper wait register holds areas 7..4
// - bits 15,11,7,3 read zero, unwritable
// - lower wait register holds areas 3..0

// ************************************************************
// register offsets (index on the plain register port)
// ************************************************************
`define AASW_OFS_ACCESS_STATE 4'h0
`define AASW_OFS_WAIT_UPPER 4'h1
`define AASW_OFS_WAIT_LOWER 4'h2
`define AASW_OFS_STATUS 4'h3

// ************************************************************
// field layout and reset values
// ************************************************************
`define AASW_ACCESS_STATE_RST 8'hFF
`define AASW_ACCESS_STATE_LSB 8
`define AASW_WAIT_FIELD_RST 3'h7
`define AASW_WAIT_FIELD_PITCH 4
`define AASW_STAT_BUSY 0
`define AASW_STAT_AREA_LSB 1
`define AASW_STAT_THREE 4
`define AASW_STAT_WAIT_LSB 5
`define AASW_STAT_LEFT_LSB 8

// ************************************************************
// bus cycle lengths in clock states
// ************************************************************
`define AASW_STATES_TWO 4'h2
`define AASW_STATES_THREE 4'h3

`endif

//--- hw/aasw_cycle_timer.v
`timescale 1ns/10ps
`default_nettype none

module aasw_cycle_timer #(
  parameter CNT_W = 4
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // cycle request
  input wire start,
  input wire [CNT_W-1:0] state_total,
  // cycle progress
  output reg busy_reg,
  output reg done_reg,
  output reg [CNT_W-1:0] left_reg
);

  // ************************************************************
  // state counter
  // ************************************************************
  // left_reg holds the states still to run after the current one
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      left_reg <= {CNT_W{1'b0}};
    end else if (start && !busy_reg) begin
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
      left_reg <= state_total - {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (busy_reg) begin
      if (left_reg == {CNT_W{1'b0}}) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b0;
      end else begin
        left_reg <= left_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        // flag the final state one edge ahead so it lines up with it
        done_reg <= (left_reg == {{(CNT_W-1){1'b0}}, 1'b1});
      end
    end else begin
      done_reg <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- tb/aasw_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module aasw_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // test control
  input wire logic en,
  input wire logic pester,
  // cycle handshake
  input wire logic cyc_busy,
  output logic cyc_start,
  output logic [2:0] cyc_area
);
  integer seed = 32'h8BF536DD;
  integer r;
  // random gaps give prompt and slow requests; pester keeps asking while busy
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_start <= 1'b0;
      cyc_area <= 3'h0;
      r <= 0;
    end else begin
      r <= $random(seed);
      cyc_area <= r[2:0];
      cyc_start <= en && (pester || (!cyc_busy && !cyc_start && r[5]));
    end
  end
endmodule
`default_nettype wire

//--- tb/aasw_cfg_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module aasw_cfg_top_sva (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // settings and cycle
  input wire [7:0] area_three_state,
  input wire [23:0] area_wait_count,
  input wire cyc_start,
  input wire [2:0] cyc_area,
  input wire cyc_three_state,
  input wire [2:0] cyc_wait_count,
  input wire cyc_busy,
  input wire cyc_last,
  input wire [3:0] cyc_states_left
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire take = cyc_start && !cyc_busy;
  wire sel_3s = area_three_state[cyc_area];
  wire [2:0] sel_w = area_wait_count[cyc_area*3 +: 3];
  property p_two; take && !sel_3s |=> !cyc_three_state && cyc_states_left == 4'h1; endproperty
  a_two: assert property (p_two) else $error("two-state cycle wrong");
  property p_three; take && sel_3s |=> cyc_three_state && cyc_states_left == $past(sel_w) + 4'h2;
  endproperty
  a_three: assert property (p_three) else $error("three-state cycle wrong");
  property p_nowait; take && !sel_3s |=> cyc_wait_count == 3'h0; endproperty
  a_nowait: assert property (p_nowait) else $error("wait in two-state");
  property p_wait; take && sel_3s |=> cyc_wait_count == $past(sel_w); endproperty
  a_wait: assert property (p_wait) else $error("wait count not applied");
  property p_cnt; cyc_busy && !cyc_last |=> cyc_busy && cyc_states_left == $past(cyc_states_left) - 4'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("state count skips");
  property p_last; cyc_last |-> cyc_busy && cyc_states_left == 4'h0 ##1 !cyc_busy; endproperty
  a_last: assert property (p_last) else $error("cycle end wrong");
  property p_ast; reg_rd && reg_addr == 4'h0 |=> reg_rdata == {$past(area_three_state), 8'h00};
  endproperty
  a_ast: assert property (p_ast) else $error("state register read wrong");
  property p_up; reg_wr && reg_addr == 4'h1 |=> area_wait_count[23:12] ==
    $past({reg_wdata[14:12], reg_wdata[10:8], reg_wdata[6:4], reg_wdata[2:0]}); endproperty
  a_up: assert property (p_up) else $error("upper waits wrong");
  property p_lo; reg_wr && reg_addr == 4'h2 |=> area_wait_count[11:0] ==
    $past({reg_wdata[14:12], reg_wdata[10:8], reg_wdata[6:4], reg_wdata[2:0]}); endproperty
  a_lo: assert property (p_lo) else $error("lower waits wrong");
  property p_rsv; reg_rd && (reg_addr == 4'h1 || reg_addr == 4'h2) |=> (reg_rdata & 16'h8888) == 16'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data lingers");
  property p_hold; !take |=> $stable(cyc_three_state) && $stable(cyc_wait_count); endproperty
  a_hold: assert property (p_hold) else $error("frozen settings moved");
  c_long: cover property (cyc_last && cyc_wait_count == 3'h7);
  c_short: cover property (cyc_last && !cyc_three_state);
  c_drop: cover property (cyc_start && cyc_busy);
endmodule
`default_nettype wire

//--- tb/aasw_cfg_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module aasw_cfg_top_tb;
  logic clk, resetn, reg_wr, reg_rd, en, pester, t;
  logic [3:0] reg_addr, a;
  logic [15:0] reg_wdata, d;
  logic [7:0] ast;
  logic [23:0] wc;
  logic [2:0] w, ar;
  wire [15:0] reg_rdata;
  wire [7:0] area_three_state;
  wire [23:0] area_wait_count;
  wire cyc_start, cyc_three_state, cyc_busy, cyc_last;
  wire [2:0] cyc_area, cyc_wait_count;
  wire [3:0] cyc_states_left;
  integer seed, fails = 0, cmp_count = 0, i, n;
  aasw_cfg_top i_aasw_cfg_top (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .area_three_state, .area_wait_count, .cyc_start, .cyc_area, .cyc_three_state, .cyc_wait_count,
    .cyc_busy, .cyc_last, .cyc_states_left);
  aasw_seq_model i_aasw_seq_model (.clk, .resetn, .en, .pester, .cyc_busy, .cyc_start, .cyc_area);
  // ************
  // tasks
  // ************
  task chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  function [15:0] pk(input [11:0] v);
    pk = {1'b0, v[11:9], 1'b0, v[8:6], 1'b0, v[5:3], 1'b0, v[2:0]};
  endfunction
  function [15:0] img(input [3:0] x);
    case (x)
      4'h0: img = {ast, 8'h00};
      4'h1: img = pk(wc[23:12]);
      4'h2: img = pk(wc[11:0]);
      // status only meaningful once the sequencer is idle
      4'h3: img = {8'h00, w, t, ar, 1'b0};
      default: img = 16'h0000;
    endcase
  endfunction
  // shadow updates one step after the taking edge, so a cycle taken there sees old settings
  task wr(input [3:0] x, input [15:0] v);
    reg_addr <= x;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    if (x == 4'h0) ast = v[15:8];
    if (x == 4'h1) wc[23:12] = {v[14:12], v[10:8], v[6:4], v[2:0]};
    if (x == 4'h2) wc[11:0] = {v[14:12], v[10:8], v[6:4], v[2:0]};
    @(posedge clk);
  endtask
  task rd(input [3:0] x);
    reg_addr <= x;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata === img(x), "read data");
    @(posedge clk);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always begin
    @(posedge clk);
    if (resetn && cyc_start && !cyc_busy) begin
      t = ast[cyc_area];
      w = t ? wc[cyc_area*3 +: 3] : 3'h0;
      ar = cyc_area;
      n = 0;
      #1 chk(cyc_three_state === t, "access kind");
      chk(cyc_wait_count === w, "wait count");
      while (cyc_busy === 1'b1 && n < 12) begin
        n++;
        @(posedge clk);
        #1;
      end
      chk(n == (t ? 3 + w : 2), "cycle length");
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
  initial begin
    seed = 32'h8BF536DD;
    {resetn, reg_wr, reg_rd, en, pester, reg_addr, reg_wdata} = '0;
    ast = 8'hFF;
    wc = 24'hFFFFFF;
    {t, w, ar} = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 4; i++) rd(i);
    rd(4'hF);
    $display("reset values done");
    en <= 1'b1;
    for (i = 0; i < 60; i++) begin
      a = $random(seed);
      d = $random(seed);
      if (a == 4'h3) a = 4'h0;
      wr(a, d);
      rd(a);
    end
    $display("random access done");
    wr(4'h0, 16'h00FF);
    repeat (40) @(posedge clk);
    wr(4'h0, 16'hFFFF);
    pester <= 1'b1;
    repeat (60) @(posedge clk);
    {pester, en} <= 2'b00;
    repeat (20) @(posedge clk);
    rd(4'h3);
    $display("cycle traffic done");
    print_verdict;
  end
endmodule
bind aasw_cfg_top aasw_cfg_top_sva i_aasw_cfg_top_sva (.clk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .area_three_state, .area_wait_count, .cyc_start, .cyc_area,
  .cyc_three_state, .cyc_wait_count, .cyc_busy, .cyc_last, .cyc_states_left);
`default_nettype wire
